// >>> design/remote_setpoint_defines.vh
// Constants for the remote setpoint and ramp block: register offsets,
// field codes, reset values and timing counts.
// Assumes a 50 MHz clock and a plain register port with 8-bit addresses.
//
// How it works
// RQ1: Select values 1 to 3 turn the three speed inputs into up, down, clear.
// RQ2: Select 1 keeps remote offset in a store, restores it at power-up.
// RQ3: With storage on, save the offset when the run command drops.
// RQ4: With up and down idle, compare once a minute, rewrite only on change.
// RQ5: Offset stays within zero and the maximum frequency setting.
// RQ6: Adjusting, second select off: longer of second and primary times.
// RQ7: Second select on always uses the second ramp times; the code uses the primary times while jog is active.
// RQ8: Select 1 or 2 lets up and down change the offset while stopped.
// RQ9: Select 3 clears the offset when run drops and never stores it.
// RQ10: Outside party should pick select 2 or 3 when changes are frequent.
// RQ11: Remote adjustment is disabled during jog or PID operation.
// RQ12: Clear then restart within a minute restores the old stored value.
// RQ13: Offset adds to the external command in external modes, mode 4 too.
// RQ14: Remote adjustment also works in network operation mode.
// RQ15: Primary ramp times span 0 to 3600 s, default 5 s or 10 s.
// RQ16: Ramp times refer to a reference frequency, 1 to 400 Hz, default 60 Hz.
// RQ17: Second ramp time spans 0 to 3600 s and applies with second select on.
// RQ18: Second decel value 9999 means use the second accel time.
// RQ19: The clear input zeroes the remote offset.
// RQ20: Select 0 keeps multi-speed meaning and makes no remote adjustment.
`ifndef REMOTE_SETPOINT_DEFINES_VH
`define REMOTE_SETPOINT_DEFINES_VH

// ****************************************************************
// Register map (byte offsets on the register port).
// ****************************************************************
`define REG_SELECT 8'h00
`define REG_PRI_ACCEL 8'h04
`define REG_PRI_DECEL 8'h08
`define REG_REF_FREQ 8'h0C
`define REG_SEC_ACCEL 8'h10
`define REG_SEC_DECEL 8'h14
`define REG_MAX_FREQ 8'h18
`define REG_OP_MODE 8'h1C
`define REG_OFFSET 8'h20
`define REG_STORED 8'h24
`define REG_STATUS 8'h28
`define REG_RAMP 8'h2C

// ****************************************************************
// Field codes and reset values.
// ****************************************************************
`define SEL_MULTI 2'h0
`define SEL_STORE 2'h1
`define SEL_NOSTORE 2'h2
`define SEL_CLEARSTOP 2'h3
`define MODE_EXT_PU 3'h4
`define MODE_NET 3'h5
`define MODE_EXT 3'h0
`define RST_TIME 16'h0032
`define RST_REF_FREQ 16'h0258
`define RST_SEC_DECEL 16'h2710
`define SEC_SAME 16'h270F
`define MAX_TIME 16'h8CA0
`define MIN_REF 16'h000A
`define MAX_REF 16'h0FA0
`define RST_MAX_FREQ 16'h04B0
`define FREQ_ZERO 16'h0000
`define SEL_MSB 1
`define MODE_MSB 2

// ****************************************************************
// Timing: one minute store interval, one 0.1 Hz step per tick.
// ****************************************************************
// Sixty seconds at 50 MHz, written out so no signed 32-bit product wraps.
`define STORE_CYCLES 32'hB2D0_5E00
`define STEP_DIV 32'd5000
`define TICK_ONE 32'h0000_0001

`endif

// >>> design/setpoint_sync.v
// Two-flip-flop synchroniser for one contact input.
// Assumes the input is asynchronous to clk and may bounce slowly.
`timescale 1ns/1ps
module setpoint_sync (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Asynchronous pin and its synchronised level.
  input wire pin_in,
  output reg level_ff
);

  reg meta_ff;

  // Only the second flop is read outside this module.
  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      level_ff <= meta_ff;
    end
  end

endmodule // setpoint_sync

// >>> design/remote_speed_setpoint_ramp.v
// Remote setpoint offset with store, clear and ramp time selection.
// Frequencies are in 0.1 Hz units, times in 0.1 s units.
// Assumes contacts and run commands are pins; jog and PID status come
// from logic on the same clock. Power cycling is modelled by rst, and
// the store models nonvolatile memory, so it survives rst.
`timescale 1ns/1ps
`include "remote_setpoint_defines.vh"
module remote_speed_setpoint_ramp #(
  parameter [31:0] STORE_INTERVAL = `STORE_CYCLES
) (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Contact and run pins.
  input wire setpoint_increase_input,
  input wire setpoint_decrease_input,
  input wire setpoint_clear_input,
  input wire forward_run_command,
  input wire reverse_run_command,
  input wire second_function_select,
  // Status from other drive logic on this clock.
  input wire jog_active,
  input wire pid_active,
  // External frequency command and whether multi-speed picked it.
  input wire [15:0] ext_freq_cmd,
  input wire multi_speed_selected,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_ff,
  // Results.
  output reg [15:0] freq_setpoint_ff,
  output reg [15:0] accel_time_ff,
  output reg [15:0] decel_time_ff,
  output reg multi_speed_mode_ff,
  output reg store_write_ff
);

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  wire inc_s;
  wire dec_s;
  wire clr_s;
  wire fwd_s;
  wire rev_s;
  wire sec_s;

  setpoint_sync u_inc (.clk(clk), .rst(rst),
    .pin_in(setpoint_increase_input), .level_ff(inc_s));
  setpoint_sync u_dec (.clk(clk), .rst(rst),
    .pin_in(setpoint_decrease_input), .level_ff(dec_s));
  setpoint_sync u_clr (.clk(clk), .rst(rst),
    .pin_in(setpoint_clear_input), .level_ff(clr_s));
  setpoint_sync u_fwd (.clk(clk), .rst(rst),
    .pin_in(forward_run_command), .level_ff(fwd_s));
  setpoint_sync u_rev (.clk(clk), .rst(rst),
    .pin_in(reverse_run_command), .level_ff(rev_s));
  setpoint_sync u_sec (.clk(clk), .rst(rst),
    .pin_in(second_function_select), .level_ff(sec_s));

  // ****************************************************************
  // Settings registers.
  // ****************************************************************
  reg [1:0] select_ff;
  reg [15:0] pri_accel_ff;
  reg [15:0] pri_decel_ff;
  reg [15:0] ref_freq_ff;
  reg [15:0] sec_accel_ff;
  reg [15:0] sec_decel_ff;
  reg [15:0] max_freq_ff;
  reg [2:0] op_mode_ff;

  // Out-of-range writes clip, so ramp math never sees illegal values.
  function [15:0] clip_time;
    input [31:0] v;
    begin
      if (v[31:16] != 16'h0000 || v[15:0] > `MAX_TIME)
        clip_time = `MAX_TIME;
      else
        clip_time = v[15:0];
    end
  endfunction

  // Settings writes; second decel accepts the same-as-accel code too.
  always @(posedge clk) begin
    if (rst) begin
      select_ff <= `SEL_MULTI;
      pri_accel_ff <= `RST_TIME; // [RQ15]
      pri_decel_ff <= `RST_TIME; // [RQ15]
      ref_freq_ff <= `RST_REF_FREQ; // [RQ16]
      sec_accel_ff <= `RST_TIME; // [RQ17]
      sec_decel_ff <= `SEC_SAME; // [RQ18]
      max_freq_ff <= `RST_MAX_FREQ;
      op_mode_ff <= `MODE_EXT;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_SELECT: select_ff <= reg_wdata[`SEL_MSB:0];
        `REG_PRI_ACCEL: pri_accel_ff <= clip_time(reg_wdata); // [RQ15]
        `REG_PRI_DECEL: pri_decel_ff <= clip_time(reg_wdata); // [RQ15]
        `REG_REF_FREQ: begin
          if (reg_wdata[15:0] < `MIN_REF)
            ref_freq_ff <= `MIN_REF; // [RQ16]
          else if (reg_wdata[31:16] != 16'h0000 ||
                   reg_wdata[15:0] > `MAX_REF)
            ref_freq_ff <= `MAX_REF; // [RQ16]
          else
            ref_freq_ff <= reg_wdata[15:0];
        end
        `REG_SEC_ACCEL: sec_accel_ff <= clip_time(reg_wdata); // [RQ17]
        `REG_SEC_DECEL: begin
          if (reg_wdata[15:0] == `SEC_SAME && reg_wdata[31:16] == 16'h0000)
            sec_decel_ff <= `SEC_SAME; // [RQ18]
          else
            sec_decel_ff <= clip_time(reg_wdata);
        end
        `REG_MAX_FREQ: max_freq_ff <= reg_wdata[15:0];
        `REG_OP_MODE: op_mode_ff <= reg_wdata[`MODE_MSB:0];
        default: select_ff <= select_ff;
      endcase
    end
  end

  // ****************************************************************
  // Remote enable and run edge.
  // ****************************************************************
  wire remote_on = (select_ff != `SEL_MULTI); // [RQ1] [RQ20]
  wire run_now = fwd_s | rev_s;
  wire mode_ok = (op_mode_ff == `MODE_EXT) || (op_mode_ff == `MODE_EXT_PU) ||
    (op_mode_ff == `MODE_NET); // [RQ13] [RQ14]
  wire adjust_ok = remote_on && mode_ok &&
    !jog_active && !pid_active; // [RQ11]
  reg run_d_ff;
  wire run_fall = run_d_ff & ~run_now;
  // Select 3 only adjusts while running; 1 and 2 also while stopped.
  wire run_gate = (select_ff != `SEL_CLEARSTOP) || run_now; // [RQ8]
  wire inc_go = adjust_ok && run_gate && inc_s && !dec_s;
  wire dec_go = adjust_ok && run_gate && dec_s && !inc_s;

  always @(posedge clk) begin
    if (rst)
      run_d_ff <= 1'b0;
    else
      run_d_ff <= run_now;
  end

  // ****************************************************************
  // Offset stepping: one 0.1 Hz step per step tick.
  // ****************************************************************
  reg [31:0] step_cnt_ff;
  wire step_tick = (step_cnt_ff == `STEP_DIV - `TICK_ONE);

  always @(posedge clk) begin
    if (rst || !(inc_go || dec_go))
      step_cnt_ff <= 32'h0000_0000;
    else if (step_tick)
      step_cnt_ff <= 32'h0000_0000;
    else
      step_cnt_ff <= step_cnt_ff + `TICK_ONE;
  end

  // ****************************************************************
  // Offset and nonvolatile store.
  // ****************************************************************
  reg [15:0] offset_ff;
  reg [15:0] stored_ff;
  reg restored_ff;
  reg [31:0] minute_cnt_ff;
  reg idle_d_ff;
  wire adj_idle = !inc_s && !dec_s;
  wire store_on = (select_ff == `SEL_STORE); // [RQ2]
  wire minute_up = (minute_cnt_ff == STORE_INTERVAL - `TICK_ONE);

  // Restore one cycle after reset release, when the store is valid.
  // Select comes up as 0 after reset, so the restore keys on the store's
  // own contents; software that keeps select 1 sees its old offset.
  // Select 0 only blocks adjustment and the sum; it must not wipe the
  // offset, or the restored value would be lost before software runs.
  reg [15:0] nxt_offset;
  always @* begin
    nxt_offset = offset_ff;
    if (!restored_ff)
      nxt_offset = stored_ff; // [RQ2] [RQ12]
    else if (adjust_ok && clr_s)
      nxt_offset = `FREQ_ZERO; // [RQ19]
    else if (select_ff == `SEL_CLEARSTOP && run_fall)
      nxt_offset = `FREQ_ZERO; // [RQ9]
    else if (inc_go && step_tick) begin
      if (offset_ff >= max_freq_ff)
        nxt_offset = max_freq_ff; // [RQ5]
      else
        nxt_offset = offset_ff + 16'h0001;
    end else if (dec_go && step_tick) begin
      if (offset_ff == `FREQ_ZERO)
        nxt_offset = `FREQ_ZERO; // [RQ5]
      else
        nxt_offset = offset_ff - 16'h0001;
    end
    if (nxt_offset > max_freq_ff)
      nxt_offset = max_freq_ff; // [RQ5]
  end

  always @(posedge clk) begin
    if (rst) begin
      offset_ff <= `FREQ_ZERO;
      restored_ff <= 1'b0;
    end else begin
      offset_ff <= nxt_offset;
      restored_ff <= 1'b1;
    end
  end

  // Minute timer restarts whenever an adjust input is active.
  always @(posedge clk) begin
    if (rst) begin
      minute_cnt_ff <= 32'h0000_0000;
      idle_d_ff <= 1'b0;
    end else begin
      idle_d_ff <= adj_idle;
      if (!adj_idle || minute_up)
        minute_cnt_ff <= 32'h0000_0000;
      else
        minute_cnt_ff <= minute_cnt_ff + `TICK_ONE; // [RQ4]
    end
  end

  // The store has no reset: it models memory that outlives power loss.
  // Writes only on run release or on the minute compare with a change.
  wire save_run = store_on && run_fall; // [RQ3]
  wire save_min = store_on && adj_idle && minute_up &&
    (offset_ff != stored_ff); // [RQ4] [RQ12]
  initial stored_ff = `FREQ_ZERO;
  always @(posedge clk) begin
    if (restored_ff && (save_run || save_min))
      stored_ff <= offset_ff;
  end

  always @(posedge clk) begin
    if (rst)
      store_write_ff <= 1'b0;
    else
      store_write_ff <= restored_ff && (save_run || save_min);
  end

  // ****************************************************************
  // Setpoint sum and ramp time selection.
  // ****************************************************************
  wire [16:0] sum = {1'b0, ext_freq_cmd} + {1'b0, offset_ff};
  wire apply = remote_on && mode_ok && !multi_speed_selected; // [RQ13]
  wire [15:0] sec_dec_eff = (sec_decel_ff == `SEC_SAME) ?
    sec_accel_ff : sec_decel_ff; // [RQ18]
  wire adjusting = inc_go || dec_go;

  always @(posedge clk) begin
    if (rst) begin
      freq_setpoint_ff <= `FREQ_ZERO;
      accel_time_ff <= `RST_TIME;
      decel_time_ff <= `RST_TIME;
      multi_speed_mode_ff <= 1'b1;
    end else begin
      multi_speed_mode_ff <= !remote_on; // [RQ20]
      if (!apply)
        freq_setpoint_ff <= ext_freq_cmd;
      else if (sum[16])
        freq_setpoint_ff <= 16'hFFFF;
      else
        freq_setpoint_ff <= sum[15:0]; // [RQ5]
      if (sec_s && !jog_active) begin
        accel_time_ff <= sec_accel_ff; // [RQ7]
        decel_time_ff <= sec_dec_eff; // [RQ7]
      end else if (adjusting) begin
        accel_time_ff <= (pri_accel_ff > sec_accel_ff) ?
          pri_accel_ff : sec_accel_ff; // [RQ6]
        decel_time_ff <= (pri_decel_ff > sec_dec_eff) ?
          pri_decel_ff : sec_dec_eff; // [RQ6]
      end else begin
        accel_time_ff <= pri_accel_ff;
        decel_time_ff <= pri_decel_ff;
      end
    end
  end

  // ****************************************************************
  // Register read: data stands in the cycle after the read strobe.
  // ****************************************************************
  always @(posedge clk) begin
    if (rst)
      reg_rdata_ff <= 32'h0000_0000;
    else if (reg_rd) begin
      case (reg_addr)
        `REG_SELECT: reg_rdata_ff <= {30'h0000_0000, select_ff};
        `REG_PRI_ACCEL: reg_rdata_ff <= {16'h0000, pri_accel_ff};
        `REG_PRI_DECEL: reg_rdata_ff <= {16'h0000, pri_decel_ff};
        `REG_REF_FREQ: reg_rdata_ff <= {16'h0000, ref_freq_ff};
        `REG_SEC_ACCEL: reg_rdata_ff <= {16'h0000, sec_accel_ff};
        `REG_SEC_DECEL: reg_rdata_ff <= {16'h0000, sec_decel_ff};
        `REG_MAX_FREQ: reg_rdata_ff <= {16'h0000, max_freq_ff};
        `REG_OP_MODE: reg_rdata_ff <= {29'h0000_0000, op_mode_ff};
        `REG_OFFSET: reg_rdata_ff <= {16'h0000, offset_ff};
        `REG_STORED: reg_rdata_ff <= {16'h0000, stored_ff};
        `REG_STATUS: reg_rdata_ff <= {26'h0000_000, adjust_ok, run_now,
          sec_s, clr_s, dec_s, inc_s};
        `REG_RAMP: reg_rdata_ff <= {accel_time_ff, decel_time_ff};
        default: reg_rdata_ff <= 32'h0000_0000;
      endcase
    end else
      reg_rdata_ff <= 32'h0000_0000;
  end

endmodule // remote_speed_setpoint_ramp

// >>> dv/contact_panel.sv
// Model of the controller or switch panel that drives the contact pins.
// Assumes the bench changes its requests just after a rising clock edge.
`timescale 1ns/1ps
module contact_panel (
  // Clock.
  input wire clk,
  // Requested levels: inc, dec, clear, forward, reverse, second select.
  input wire [5:0] req,
  // Contact and run pins.
  output reg [5:0] pins_ff
);
  // All contacts switch together from one latch, like a relay card.
  // The panel is not reset by the drive, so pins survive a power cycle.
  always @(posedge clk) begin
    pins_ff <= req;
  end
endmodule // contact_panel

// >>> dv/remote_speed_setpoint_ramp_assertions.sv
// Checker for the remote setpoint block, seeing its top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module remote_setpoint_checker #(
  parameter [31:0] STORE_INTERVAL = 32'd200
) (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Pins and drive status.
  input wire setpoint_increase_input,
  input wire setpoint_clear_input,
  input wire forward_run_command,
  input wire reverse_run_command,
  input wire jog_active,
  input wire pid_active,
  input wire [15:0] ext_freq_cmd,
  input wire multi_speed_selected,
  input wire reg_wr,
  // Results.
  input wire [15:0] freq_setpoint_ff,
  input wire [15:0] accel_time_ff,
  input wire [15:0] decel_time_ff,
  input wire multi_speed_mode_ff,
  input wire store_write_ff
);
  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Reset must be watched while it is high, so it has no disable.
  property p_reset;
    disable iff (1'b0) rst |=> freq_setpoint_ff == 16'h0000 &&
      accel_time_ff == 16'h0032 && decel_time_ff == 16'h0032 &&
      multi_speed_mode_ff;
  endproperty
  property p_time_max;
    accel_time_ff <= 16'h8CA0 && decel_time_ff <= 16'h8CA0;
  endproperty
  // Windows of six cycles cover the two sync flops and the output stage.
  property p_jog;
    (jog_active && !reg_wr && $stable(ext_freq_cmd) &&
      $stable(multi_speed_selected))[*6] |-> $stable(freq_setpoint_ff);
  endproperty
  property p_clear;
    (setpoint_clear_input && !jog_active && !pid_active &&
      $stable(ext_freq_cmd))[*6] |-> freq_setpoint_ff == ext_freq_cmd;
  endproperty
  property p_multi;
    (multi_speed_selected && $stable(ext_freq_cmd))[*4] |->
      freq_setpoint_ff == ext_freq_cmd;
  endproperty
  property p_floor;
    $stable(ext_freq_cmd)[*6] |-> freq_setpoint_ff >= ext_freq_cmd;
  endproperty
  property p_no_store_adjust;
    (setpoint_increase_input && $stable(forward_run_command) &&
      $stable(reverse_run_command))[*8] |-> !store_write_ff;
  endproperty
  property p_store_pulse;
    store_write_ff |=> !store_write_ff;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset values wrong");
  a_time_max: assert property (p_time_max)
    else $error("ramp time above limit");
  a_jog: assert property (p_jog)
    else $error("setpoint moved while disabled");
  a_clear: assert property (p_clear)
    else $error("clear left an offset");
  a_multi: assert property (p_multi)
    else $error("offset added to multi-speed");
  a_floor: assert property (p_floor)
    else $error("setpoint below command");
  a_no_store_adjust: assert property (p_no_store_adjust)
    else $error("store written while adjusting");
  a_store_pulse: assert property (p_store_pulse)
    else $error("store pulse too long");
  // Main scenarios.
  c_store: cover property (store_write_ff);
  c_clear: cover property (setpoint_clear_input[*6]);
  c_jog: cover property (jog_active[*8]);
endmodule // remote_setpoint_checker

bind remote_speed_setpoint_ramp remote_setpoint_checker #(
  .STORE_INTERVAL(STORE_INTERVAL)
) chk_inst (
  .clk(clk), .rst(rst),
  .setpoint_increase_input(setpoint_increase_input),
  .setpoint_clear_input(setpoint_clear_input),
  .forward_run_command(forward_run_command),
  .reverse_run_command(reverse_run_command),
  .jog_active(jog_active), .pid_active(pid_active),
  .ext_freq_cmd(ext_freq_cmd), .multi_speed_selected(multi_speed_selected),
  .reg_wr(reg_wr), .freq_setpoint_ff(freq_setpoint_ff),
  .accel_time_ff(accel_time_ff), .decel_time_ff(decel_time_ff),
  .multi_speed_mode_ff(multi_speed_mode_ff), .store_write_ff(store_write_ff)
);

// >>> dv/tb.sv
// Bench for the remote setpoint block: ramp cases, a table of register cases, then
// storage, restart, clear and disable cases written by hand.
// Assumes the design, the panel model and the checker are compiled first.
`timescale 1ns/1ps
`include "remote_setpoint_defines.vh"
module tb;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic [15:0] s;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] req = 6'h00;
  wire [5:0] pins;
  logic jog_active = 1'b0;
  logic pid_active = 1'b0;
  logic [15:0] ext_freq_cmd = 16'h0100;
  logic multi_speed_selected = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [31:0] reg_rdata_ff;
  wire [15:0] freq_setpoint_ff;
  wire [15:0] accel_time_ff;
  wire [15:0] decel_time_ff;
  wire multi_speed_mode_ff;
  wire store_write_ff;
  int n_mismatch = 0;
  int checked = 0;
  int n_store = 0;
  // Clipped times, clipped reference, and operation modes with the offset.
  row_t rows [10] = '{
    '{8'h04, 32'h0000_9C40, 32'h0000_8CA0, 16'h0101},
    '{8'h08, 32'h0000_0000, 32'h0000_0000, 16'h0101},
    '{8'h10, 32'h0000_8CA0, 32'h0000_8CA0, 16'h0101},
    '{8'h14, 32'h0000_270F, 32'h0000_270F, 16'h0101},
    '{8'h0C, 32'h0000_0005, 32'h0000_000A, 16'h0101},
    '{8'h0C, 32'h0000_0FA1, 32'h0000_0FA0, 16'h0101},
    '{8'h1C, 32'h0000_0004, 32'h0000_0004, 16'h0101},
    '{8'h1C, 32'h0000_0005, 32'h0000_0005, 16'h0101},
    '{8'h1C, 32'h0000_0001, 32'h0000_0001, 16'h0100},
    '{8'h1C, 32'h0000_0000, 32'h0000_0000, 16'h0101}};

  // ****************************************************************
  // Design, panel and clock.
  // ****************************************************************
  always #10 clk = ~clk;
  contact_panel contact_panel_inst (.clk(clk), .req(req), .pins_ff(pins));
  remote_speed_setpoint_ramp #(
    .STORE_INTERVAL(32'd200)
  ) remote_speed_setpoint_ramp_inst (
    .clk(clk), .rst(rst),
    .setpoint_increase_input(pins[0]), .setpoint_decrease_input(pins[1]),
    .setpoint_clear_input(pins[2]), .forward_run_command(pins[3]),
    .reverse_run_command(pins[4]), .second_function_select(pins[5]),
    .jog_active(jog_active), .pid_active(pid_active),
    .ext_freq_cmd(ext_freq_cmd), .multi_speed_selected(multi_speed_selected),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .freq_setpoint_ff(freq_setpoint_ff), .accel_time_ff(accel_time_ff),
    .decel_time_ff(decel_time_ff), .multi_speed_mode_ff(multi_speed_mode_ff),
    .store_write_ff(store_write_ff)
  );
  // Count store writes, so later cases can tell a rewrite from none.
  always @(posedge clk) begin
    if (store_write_ff === 1'b1) n_store <= n_store + 1;
  end

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_ff, e);
  endtask
  // Power cycle: the store keeps its value across it.
  task automatic pwr;
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(2);
  endtask
  // Hold one set of contacts for n cycles, then let sync flops settle.
  task automatic hold(input logic [5:0] m, input int n);
    req <= m;
    cyc(n);
    req <= 6'h00;
    cyc(8);
  endtask
  task automatic end_of_test;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  // A hang anywhere counts as a mismatch and ends the run.
  initial begin
    cyc(100000);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    #1;
    chk(accel_time_ff, 32'h0000_0032);
    chk(multi_speed_mode_ff, 32'h0000_0001);
    rd(`REG_PRI_DECEL, 32'h0000_0032);
    rd(`REG_REF_FREQ, 32'h0000_0258);
    rd(`REG_SEC_ACCEL, 32'h0000_0032);
    rd(`REG_SEC_DECEL, 32'h0000_270F);
    rd(8'h30, 32'h0000_0000);
    wr(`REG_MAX_FREQ, 32'h0000_0001);
    wr(`REG_PRI_ACCEL, 32'h0000_0064);
    wr(`REG_SEC_ACCEL, 32'h0000_00C8);
    wr(`REG_PRI_DECEL, 32'h0000_012C);
    wr(`REG_SELECT, 32'h0000_0002);
    // Stopped, adjusting: longer of second and primary; offset clamps at 1.
    req <= 6'h01;
    cyc(100);
    chk(accel_time_ff, 32'h0000_00C8);
    chk(decel_time_ff, 32'h0000_012C);
    hold(6'h01, 11000);
    rd(`REG_OFFSET, 32'h0000_0001);
    chk(freq_setpoint_ff, 32'h0000_0101);
    chk(accel_time_ff, 32'h0000_0064);
    // Second select on: second times even though primary decel is longer.
    req <= 6'h22;
    cyc(100);
    chk(decel_time_ff, 32'h0000_00C8);
    hold(6'h22, 11000);
    rd(`REG_OFFSET, 32'h0000_0000);
    hold(6'h01, 6000);
    for (int i = 0; i < 10; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].r);
      cyc(3);
      chk(freq_setpoint_ff, rows[i].s);
    end
    multi_speed_selected <= 1'b1;
    ext_freq_cmd <= 16'h0200;
    cyc(4);
    chk(freq_setpoint_ff, 32'h0000_0200);
    multi_speed_selected <= 1'b0;
    // Jog, then PID: lowering must have no effect.
    for (int k = 0; k < 2; k++) begin
      jog_active <= (k == 0);
      pid_active <= (k == 1);
      hold(6'h02, 6000);
      rd(`REG_OFFSET, 32'h0000_0001);
    end
    jog_active <= 1'b0;
    pid_active <= 1'b0;
    // Storage on: run drop saves, equal values are not rewritten.
    wr(`REG_SELECT, 32'h0000_0001);
    hold(6'h10, 8);
    cyc(12);
    chk(n_store, 32'h0000_0001);
    rd(`REG_STORED, 32'h0000_0001);
    cyc(300);
    chk(n_store, 32'h0000_0001);
    pwr;
    rd(`REG_OFFSET, 32'h0000_0001);
    // Clear, then restart inside the minute: old stored value returns.
    wr(`REG_SELECT, 32'h0000_0001);
    hold(6'h01, 10);
    hold(6'h04, 10);
    rd(`REG_OFFSET, 32'h0000_0000);
    pwr;
    rd(`REG_OFFSET, 32'h0000_0001);
    // Clear, then restart after the minute: cleared value returns.
    wr(`REG_SELECT, 32'h0000_0001);
    hold(6'h04, 10);
    cyc(300);
    chk(n_store, 32'h0000_0002);
    pwr;
    rd(`REG_OFFSET, 32'h0000_0000);
    // Clear-on-stop mode: adjusts while running, run drop clears, no store.
    wr(`REG_SELECT, 32'h0000_0003);
    req <= 6'h08;
    cyc(8);
    hold(6'h09, 6000);
    rd(`REG_OFFSET, 32'h0000_0000);
    chk(n_store, 32'h0000_0002);
    // Multi-speed meaning: contacts make no remote adjustment.
    wr(`REG_SELECT, 32'h0000_0000);
    hold(6'h01, 6000);
    rd(`REG_OFFSET, 32'h0000_0000);
    chk(multi_speed_mode_ff, 32'h0000_0001);
    end_of_test;
  end
endmodule // tb
